// ===== pkg/dex_pkg.sv
// Shared constants for the decrement instruction execution block
package dex_pkg;
  localparam int          WORD_W        = 16;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 8;
  localparam int          PC_W          = 16;
  localparam logic [6:0]  OPC_DEC       = 7'h03;
  localparam logic [6:0]  OPC_DSZ       = 7'h0B;
  localparam logic [6:0]  OPC_DAW       = 7'h17;
  localparam int          OPC_LSB       = 9;
  localparam int          DEST_BIT      = 8;
  localparam logic [1:0]  Q_FIRST       = 2'h0;
  localparam logic [1:0]  Q_LAST        = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [3:0]  FLAGS_RESET   = 4'h0;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_HC       = 1;
  localparam int          FLAG_Z        = 2;
  localparam int          FLAG_OV       = 3;
  typedef enum logic [1:0] {
    DEX_Q1,
    DEX_Q2,
    DEX_Q3,
    DEX_Q4
  } dex_q_e;
endpackage

// ===== design/dex_file_mem.sv
// Data memory for file registers with registered read data
module dex_file_mem
  import dex_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input  wire logic              sys_clk,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== design/dex_exec.sv
// Execution of decrement, decrement-and-skip and decimal-adjust write phase
// Notes on behaviour
// - Decrement is decoded from 0000 011d ffff ffff and updates overflow, carry, half-carry, zero.
// - Decrement is one word, one cycle: decode, read, execute, write in the four quarters.
// - Decrement-and-skip writes f-1 to the working register for d 0, else to file f.
// - A zero result of decrement-and-skip discards the fetched instruction, taking two cycles.
// - Decrement-and-skip is decoded from 0001 011d ffff ffff and changes no flag.
// - Decimal adjust writes its result in the fourth quarter to file f, and also to the working register for s 0.
module dex_exec
  import dex_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [WORD_W-1:0] instr,
  output logic      [PC_W-1:0]   pc,
  output logic      [DATA_W-1:0] working_register,
  output logic                   carry_flag,
  output logic                   half_carry_flag,
  output logic                   zero_flag,
  output logic                   signed_overflow_flag,
  output logic      [1:0]        quarter,
  output logic                   skipping,
  output logic                   file_wr_en,
  output logic      [ADDR_W-1:0] file_wr_addr,
  output logic      [DATA_W-1:0] file_wr_data
);
  dex_q_e            q_state;
  dex_q_e            next_q;
  logic [WORD_W-1:0] ir;
  logic              skip_cyc;
  logic [DATA_W-1:0] file_rd;
  logic [DATA_W-1:0] result;
  logic [3:0]        flags;

  // Decode fields
  wire [6:0]        opc       = ir[WORD_W-1:OPC_LSB];
  wire              dest      = ir[DEST_BIT];
  wire [ADDR_W-1:0] faddr     = ir[ADDR_W-1:0];
  wire              is_dec    = (opc == OPC_DEC);
  wire              is_dsz    = (opc == OPC_DSZ);
  wire              is_daw    = (opc == OPC_DAW);
  wire              active    = !skip_cyc;
  wire              in_q3     = (q_state == DEX_Q3);
  wire              in_q4     = (q_state == DEX_Q4);
  wire [DATA_W-1:0] dec_val   = file_rd - 8'h01;
  wire              dec_hc    = (file_rd[3:0] != 4'h0);
  wire              dec_ov    = (file_rd == 8'h80);
  wire              dec_c     = (file_rd != 8'h00);
  wire              dec_zero  = (dec_val == 8'h00);
  // Decimal adjust from working register, carry flag and half-carry flag
  wire              adj_lo    = (working_register[3:0] > 4'h9) || flags[FLAG_HC];
  wire [8:0]        lo_sum    = {1'b0, working_register} + (adj_lo ? 9'h006 : 9'h000);
  wire              adj_hi    = (lo_sum[7:4] > 4'h9) || flags[FLAG_C] || lo_sum[8];
  wire [8:0]        daw_sum   = lo_sum + (adj_hi ? 9'h060 : 9'h000);
  wire              do_write  = active && in_q4 && (is_dec || is_dsz || is_daw);
  wire              wr_file   = do_write && (dest || is_daw);
  wire              wr_w      = do_write && !dest;
  wire              take_skip = active && in_q4 && is_dsz && (result == 8'h00);

  assign quarter              = q_state;
  assign skipping             = skip_cyc;
  assign carry_flag           = flags[FLAG_C];
  assign half_carry_flag      = flags[FLAG_HC];
  assign zero_flag            = flags[FLAG_Z];
  assign signed_overflow_flag = flags[FLAG_OV];

  always_comb begin
    case (q_state)
      DEX_Q1:  next_q = DEX_Q2;
      DEX_Q2:  next_q = DEX_Q3;
      DEX_Q3:  next_q = DEX_Q4;
      DEX_Q4:  next_q = DEX_Q1;
      default: next_q = DEX_Q1;
    endcase
  end

  dex_file_mem u_mem (
    .sys_clk (sys_clk),
    .rd_addr (faddr),
    .rd_data (file_rd),
    .wr_en   (file_wr_en),
    .wr_addr (file_wr_addr),
    .wr_data (file_wr_data)
  );

  // Quarter sequencer and instruction latch
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      q_state <= DEX_Q1;
      ir      <= '0;
    end else begin
      q_state <= next_q;
      if (q_state == DEX_Q1) begin
        ir <= instr;
      end
    end
  end

  // Skip control and program counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      skip_cyc <= 1'b0;
      pc       <= PC_RESET;
    end else if (in_q4) begin
      skip_cyc <= take_skip;
      pc       <= pc + 16'h0001;
    end
  end

  // Execute stage and register writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result           <= '0;
      working_register <= W_RESET;
      flags            <= FLAGS_RESET;
      file_wr_en       <= 1'b0;
      file_wr_addr     <= '0;
      file_wr_data     <= '0;
    end else begin
      file_wr_en <= 1'b0;
      if (active && in_q3) begin
        result <= is_daw ? daw_sum[7:0] : dec_val;
        if (is_dec) begin
          flags <= {dec_ov, dec_zero, dec_hc, dec_c};
        end else if (is_daw) begin
          flags[FLAG_C] <= daw_sum[8] | adj_hi;
        end
      end
      if (wr_w) begin
        working_register <= result;
      end
      if (wr_file) begin
        file_wr_en   <= 1'b1;
        file_wr_addr <= faddr;
        file_wr_data <= result;
      end
    end
  end

  a_skip_no_write: assert property (@(posedge sys_clk) disable iff (srst)
    skip_cyc |-> !wr_w && !wr_file) else $error("write in skipped cycle");
  a_skip_flags: assert property (@(posedge sys_clk) disable iff (srst)
    skip_cyc && in_q3 |=> $stable(flags)) else $error("flags moved in skip");
  a_dsz_flags: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q3 && is_dsz |=> $stable(flags)) else $error("dsz changed flags");
  a_dec_zero: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q3 && is_dec |=> zero_flag == (result == 8'h00))
    else $error("zero flag wrong");
  a_dec_to_w: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && (is_dec || is_dsz) && !dest |=> working_register == $past(result))
    else $error("w not written");
  a_dec_to_file: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && (is_dec || is_dsz) && dest |=> file_wr_en && file_wr_data == $past(result))
    else $error("file not written");
  a_skip_set: assert property (@(posedge sys_clk) disable iff (srst)
    take_skip |=> skip_cyc [*4]) else $error("skip not held");
  a_daw_file: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && is_daw |=> file_wr_en) else $error("daw file write missing");
  a_quarter_seq: assert property (@(posedge sys_clk) disable iff (srst)
    in_q4 |=> q_state == DEX_Q1 ##1 q_state == DEX_Q2) else $error("quarter order");
  a_pc_step: assert property (@(posedge sys_clk) disable iff (srst)
    in_q4 |=> pc == $past(pc) + 16'h0001) else $error("pc not advanced");

  a_pc_hold: assert property (@(posedge sys_clk) disable iff (srst)
    !in_q4 |=> $stable(pc))
    else $error("pc moved mid cycle");

  a_reset_state: assert property (@(posedge sys_clk)
    srst |=> q_state == DEX_Q1 && pc == PC_RESET && !file_wr_en)
    else $error("reset state wrong");

  a_w_q4_only: assert property (@(posedge sys_clk) disable iff (srst)
    !in_q4 |=> $stable(working_register))
    else $error("w written outside last quarter");

  a_dec_value: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q3 && (is_dec || is_dsz) |=> result == $past(dec_val))
    else $error("decrement value wrong");

  a_dec_carry: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q3 && is_dec |=> carry_flag == $past(dec_c))
    else $error("carry flag wrong");

  a_dec_half: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q3 && is_dec |=> half_carry_flag == $past(dec_hc))
    else $error("half carry flag wrong");

  a_dec_ovf: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q3 && is_dec |=> signed_overflow_flag == $past(dec_ov))
    else $error("overflow flag wrong");

  a_daw_w: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && is_daw && !dest |=> working_register == $past(result))
    else $error("daw w not written");

  a_daw_s_keep: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && is_daw && dest |=> $stable(working_register))
    else $error("daw wrote w with s set");

  a_no_skip_nz: assert property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && is_dsz && result != 8'h00 |=> !skip_cyc)
    else $error("skip on nonzero");

  a_other_idle: assert property (@(posedge sys_clk) disable iff (srst)
    in_q4 && !(is_dec || is_dsz || is_daw) |=> !file_wr_en && $stable(working_register))
    else $error("unknown opcode wrote");

  a_wr_pulse: assert property (@(posedge sys_clk) disable iff (srst)
    file_wr_en |=> !file_wr_en)
    else $error("file write longer than one cycle");

  a_skip_pc: assert property (@(posedge sys_clk) disable iff (srst)
    skip_cyc && in_q4 |=> pc == $past(pc) + 16'h0001)
    else $error("pc stalled in skip");

  c_skip: cover property (@(posedge sys_clk) disable iff (srst) take_skip);
  c_dec_w: cover property (@(posedge sys_clk) disable iff (srst) wr_w && is_dec);
  c_dsz_file: cover property (@(posedge sys_clk) disable iff (srst) wr_file && is_dsz);
  c_daw: cover property (@(posedge sys_clk) disable iff (srst) wr_file && is_daw);
  c_dsz_noskip: cover property (@(posedge sys_clk) disable iff (srst)
    active && in_q4 && is_dsz && result != 8'h00);
endmodule

// ===== dv/tb.sv
// Self-checking random testbench for the decrement instruction execution block
module tb
  import dex_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              sys_clk;
  logic              srst;
  logic [WORD_W-1:0] instr;
  logic [PC_W-1:0]   pc;
  logic [DATA_W-1:0] working_register;
  logic              carry_flag;
  logic              half_carry_flag;
  logic              zero_flag;
  logic              signed_overflow_flag;
  logic [1:0]        quarter;
  logic              skipping;
  logic              file_wr_en;
  logic [ADDR_W-1:0] file_wr_addr;
  logic [DATA_W-1:0] file_wr_data;
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] e_w;
  logic [DATA_W-1:0] e_data;
  logic [ADDR_W-1:0] e_addr;
  logic [PC_W-1:0]   e_pc;
  logic [3:0]        e_fl;
  logic              e_skip;
  logic              e_we;
  logic [31:0]       seed;
  logic [6:0]        op;
  int                bad_count = 0;
  int                checks = 0;
  int                cycles = 0;

  dex_exec DUT (.sys_clk, .srst, .instr, .pc, .working_register, .carry_flag,
    .half_carry_flag, .zero_flag, .signed_overflow_flag, .quarter, .skipping,
    .file_wr_en, .file_wr_addr, .file_wr_data);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic [8:0] daw_exp(input logic [7:0] w, input logic c, input logic hc);
    logic [8:0] s;
    logic       hi;
    s = {1'b0, w} + ((w[3:0] > 4'h9 || hc) ? 9'h006 : 9'h000);
    hi = s[7:4] > 4'h9 || c || s[8];
    s = s + (hi ? 9'h060 : 9'h000);
    return {s[8] | hi, s[7:0]};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One instruction cycle, starting just after an edge with quarter 0
  task automatic run(input logic [15:0] w);
    logic [7:0] m;
    logic [7:0] r;
    logic [8:0] d;
    m = mem[w[7:0]];
    d = daw_exp(e_w, e_fl[0], e_fl[1]);
    r = m - 8'h01;
    e_we = 1'b0;
    instr = w;
    if (e_skip) e_skip = 1'b0;
    else if (w[15:9] === OPC_DEC || w[15:9] === OPC_DSZ) begin
      if (w[8]) begin
        mem[w[7:0]] = r;
        e_we = 1'b1;
        e_addr = w[7:0];
        e_data = r;
      end else e_w = r;
      if (w[15:9] === OPC_DEC) e_fl = {m == 8'h80, r == 8'h00, m[3:0] != 4'h0, m != 8'h00};
      else e_skip = (r == 8'h00);
    end else if (w[15:9] === OPC_DAW) begin
      mem[w[7:0]] = d[7:0];
      e_we = 1'b1;
      e_addr = w[7:0];
      e_data = d[7:0];
      if (!w[8]) e_w = d[7:0];
      e_fl[0] = d[8];
    end
    e_pc++;
    repeat (4) @(posedge sys_clk);
    #1;
    cmp(16'(quarter), 16'(Q_FIRST));
    cmp(pc, e_pc);
    cmp(16'(working_register), 16'(e_w));
    cmp(16'({signed_overflow_flag, zero_flag, half_carry_flag, carry_flag}), 16'(e_fl));
    cmp(16'(skipping), 16'(e_skip));
    cmp(16'(file_wr_en), 16'(e_we));
    if (e_we) cmp({file_wr_addr, file_wr_data}, {e_addr, e_data});
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    srst = 1'b1;
    instr = 16'h0000;
    seed = 32'hD5E7;
    e_pc = 16'h0000;
    e_w = 8'h00;
    e_fl = 4'h0;
    e_skip = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    cmp(pc, PC_RESET);
    cmp(16'(working_register), 16'(W_RESET));
    cmp(16'(quarter), 16'(Q_FIRST));
    // Clear the two used file locations, s both ways
    run({OPC_DAW, 1'b1, 8'h00});
    run({OPC_DAW, 1'b0, 8'h81});
    // Corners: borrow from zero, skip-decrement to W, unknown opcode
    run({OPC_DEC, 1'b1, 8'h00});
    run({OPC_DSZ, 1'b0, 8'h00});
    run(16'hFFFF);
    for (int i = 0; i < 3000; i++) begin
      seed = lfsr(seed);
      op = seed[5] ? (seed[4] ? 7'h7F : OPC_DAW) : (seed[4] ? OPC_DSZ : OPC_DEC);
      run({op, seed[2] | seed[3], seed[0], 6'h00, seed[0]});
    end
    results();
  end
endmodule
